// file: osf_defs.svh
// Constants for the octal serial flash bus front end
`ifndef OSF_DEFS_SVH
`define OSF_DEFS_SVH

// Volatile configuration location 00h values and strobe enable bit
`define OSF_CFG_SDR_DS    8'hff
`define OSF_CFG_SDR       8'hdf
`define OSF_CFG_DDR_DS    8'he7
`define OSF_CFG_DDR       8'hc7
`define OSF_CFG_DS_BIT    5

// Instruction codes
`define OSF_CMD_FAST_READ 8'h0b
`define OSF_CMD_OCT_OUT   8'h8b
`define OSF_CMD_OCT_IO    8'hcb
`define OSF_CMD_DDR_READ  8'h9d
`define OSF_CMD_RD_STAT_A 8'h05
`define OSF_CMD_RD_STAT_B 8'h0f
`define OSF_CMD_WR_STAT_A 8'h01
`define OSF_CMD_WR_STAT_B 8'h1f
`define OSF_CMD_WR_EN     8'h06
`define OSF_CMD_LOAD      8'h02
`define OSF_CMD_PROG_EXEC 8'h10
`define OSF_CMD_ERASE     8'hd8
`define OSF_CMD_PAGE_READ 8'h13

// Header lengths
`define OSF_AB_COL        2'd2
`define OSF_AB_ROW        2'd3
`define OSF_AB_REG        2'd1
`define OSF_DUMMY_CYC     6'd8

// Protection
`define OSF_PROT_SEL      8'ha0
`define OSF_BLOCKS        10'd512
`define OSF_BP_ALL        4'd10
`define OSF_SRP_LOCKED    2'b11

`endif

// file: osf_front_end.sv
// Octal serial flash bus front end: link-side shifter and system-side hand-off
`timescale 1ns/1ps
`default_nettype none
`include "osf_defs.svh"
module osf_front_end import osf_pkg::*; (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_hw_reset_n,
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic [7:0]  i_io,
	output logic      [7:0]  o_io,
	output logic      [7:0]  o_io_oe,
	output logic             o_read_strobe_out,
	output logic             o_read_strobe_oe,
	input  wire logic [7:0]  i_vol_cfg,
	input  wire logic        i_wp_enable,
	input  wire logic [3:0]  i_block_protect_level,
	input  wire logic [1:0]  i_status_protect_bits,
	output logic      [12:0] o_rd_addr,
	input  wire logic [15:0] i_rd_data,
	output logic      [15:0] o_wr_data,
	output logic      [1:0]  o_wr_valid,
	output logic             o_cmd_valid,
	output logic      [7:0]  o_cmd,
	output logic      [23:0] o_addr,
	output logic             o_cmd_refused,
	output logic             o_hw_reset_active,
	output logic             o_selected
);
	// System-clock side
	logic [2:0]  pin_s;
	logic        hw_rst_s;
	logic        cs_n_s;
	logic        wp_n_s;
	logic        armed_reg;
	logic [16:0] cfg_bus_reg;
	logic        evt_s;
	logic        evt_prev_reg;
	logic        evt_seen;

	osf_sync #(.W(3), .RST_VAL(3'b111)) u_pin_sync (
		.i_clk   (i_sys_clk),
		.i_rst_n (i_resetn),
		.i_d     ({i_hw_reset_n, i_cs_n, i_io[2]}),
		.o_q     (pin_s)
	);
	assign hw_rst_s = pin_s[2];
	assign cs_n_s   = pin_s[1];
	assign wp_n_s   = pin_s[0];

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			armed_reg <= 1'b0;
		end else if (!hw_rst_s) begin
			armed_reg <= 1'b0;
		end else if (cs_n_s) begin
			armed_reg <= 1'b1;
		end
	end

	// Configuration is static during a frame, so a level crossing suffices
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_bus_reg <= 17'h0;
		end else begin
			cfg_bus_reg <= {armed_reg, wp_n_s, i_wp_enable, i_block_protect_level,
				i_status_protect_bits, i_vol_cfg};
		end
	end

	// Link side
	wire persist_rst_n = i_resetn & i_hw_reset_n;
	wire link_rst_n    = persist_rst_n & ~i_cs_n;

	logic [16:0] lk_cfg;
	osf_sync #(.W(17), .RST_VAL(17'h0)) u_cfg_sync (
		.i_clk   (i_sck),
		.i_rst_n (persist_rst_n),
		.i_d     (cfg_bus_reg),
		.o_q     (lk_cfg)
	);
	wire       lk_armed = lk_cfg[16];
	wire       lk_wp_n  = lk_cfg[15];
	wire       lk_wp_en = lk_cfg[14];
	wire [3:0] lk_bp    = lk_cfg[13:10];
	wire [1:0] lk_srp   = lk_cfg[9:8];
	wire [7:0] lk_vcr   = lk_cfg[7:0];

	// Other configuration values fall back to single rate
	wire ddr_mode = (lk_vcr == `OSF_CFG_DDR_DS) | (lk_vcr == `OSF_CFG_DDR);
	wire ds_en    = lk_vcr[`OSF_CFG_DS_BIT];

	osf_state_t  state_reg;
	osf_state_t  state_next;
	logic [5:0]  cnt_reg;
	logic [5:0]  cnt_next;
	logic [7:0]  cmd_reg;
	logic [23:0] addr_reg;
	logic [23:0] addr_next;
	logic [12:0] col_reg;
	logic [12:0] col_next;
	logic        refused_reg;
	logic [7:0]  pos_byte_reg;
	logic [7:0]  neg_byte_reg;
	logic [7:0]  pos_out_reg;
	logic [7:0]  neg_out_reg;
	logic        pos_ds_reg;
	logic        neg_ds_reg;
	logic [7:0]  wr_sh_reg;
	logic        evt_tog_reg;
	logic [7:0]  held_cmd_reg;
	logic [23:0] held_addr_reg;
	logic        held_ref_reg;

	// Command: pin 0 one bit per rising edge, or a whole byte in double rate mode
	wire [7:0] cmd_full = ddr_mode ? i_io : {cmd_reg[6:0], i_io[0]};
	wire       cmd_done = (state_reg == OSF_ST_CMD) & (ddr_mode | (cnt_reg == 6'd7));
	wire [7:0] dec      = (state_reg == OSF_ST_CMD) ? cmd_full : cmd_reg;

	// Instruction decode
	wire c_fast  = dec == `OSF_CMD_FAST_READ;
	wire c_ooct  = dec == `OSF_CMD_OCT_OUT;
	wire c_ioct  = dec == `OSF_CMD_OCT_IO;
	wire c_ddr   = dec == `OSF_CMD_DDR_READ;
	wire c_rstat = (dec == `OSF_CMD_RD_STAT_A) | (dec == `OSF_CMD_RD_STAT_B);
	wire c_wstat = (dec == `OSF_CMD_WR_STAT_A) | (dec == `OSF_CMD_WR_STAT_B);
	wire c_load  = dec == `OSF_CMD_LOAD;
	wire c_row   = (dec == `OSF_CMD_PROG_EXEC) | (dec == `OSF_CMD_ERASE);
	wire c_pread = dec == `OSF_CMD_PAGE_READ;
	wire c_wen   = dec == `OSF_CMD_WR_EN;
	wire is_read = c_fast | c_ooct | c_ioct | c_ddr | c_rstat;
	wire is_wr   = c_wstat | c_load | c_row | c_wen;
	wire data_in = c_wstat | c_load;
	wire known   = is_read | is_wr | c_pread;
	wire oct_op  = ddr_mode | c_ooct | c_ioct | c_ddr;

	wire [1:0] ab = (c_fast | c_ooct | c_ioct | c_ddr | c_load) ? `OSF_AB_COL :
		(c_row | c_pread) ? `OSF_AB_ROW : (c_rstat | c_wstat) ? `OSF_AB_REG : 2'd0;
	wire [5:0] dummy = (c_fast | c_ooct | c_ioct | c_ddr) ? `OSF_DUMMY_CYC : 6'd0;

	osf_width_t addr_w;
	osf_width_t data_w;
	assign addr_w = (ddr_mode | c_ddr) ? OSF_W_DDR : c_ioct ? OSF_W_OCTAL : OSF_W_SINGLE;
	assign data_w = (ddr_mode | c_ddr) ? OSF_W_DDR :
		(c_ooct | c_ioct) ? OSF_W_OCTAL : OSF_W_SINGLE;

	// Last address edge: bits, bytes, or the edge that assembles the last byte pair
	wire [5:0] addr_last = (addr_w == OSF_W_SINGLE) ? ({1'b0, ab, 3'b000} - 6'd1) :
		(addr_w == OSF_W_OCTAL) ? ({4'h0, ab} - 6'd1) : ((ab == 2'd3) ? 6'd2 : 6'd1);

	logic [23:0] addr_shift;
	assign addr_shift = (addr_w == OSF_W_SINGLE) ? {addr_reg[22:0], i_io[0]} :
		(addr_w == OSF_W_OCTAL) ? {addr_reg[15:0], i_io} :
		(cnt_reg != 6'd0) ? {addr_reg[7:0], pos_byte_reg, neg_byte_reg} : addr_reg;

	wire addr_done = (state_reg == OSF_ST_ADDR) & (cnt_reg == addr_last);
	wire decide    = (cmd_done & (ab == 2'd0)) | addr_done;
	wire [23:0] addr_dec = addr_done ? addr_shift : 24'h0;

	// Protection checks
	wire [9:0] blk     = addr_dec[15:6];
	wire [9:0] bp_base = `OSF_BLOCKS - (10'd1 << (lk_bp - 4'd1));
	wire region_prot   = (lk_bp != 4'h0) & ((lk_bp >= `OSF_BP_ALL) | (blk >= bp_base));
	wire wp_low        = ~lk_wp_n & ~ddr_mode;
	wire hw_lock       = lk_wp_en & wp_low & is_wr;
	wire oct_rd_lock   = lk_wp_en & is_read & oct_op;
	wire prot_reg_lock = c_wstat & (addr_dec[7:0] == `OSF_PROT_SEL) &
		((~lk_wp_en & wp_low & lk_srp[0]) | (lk_srp == `OSF_SRP_LOCKED));
	wire refuse = ~lk_armed | ~known | hw_lock | oct_rd_lock | prot_reg_lock |
		(c_row & region_prot);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 6'd1;
		case (state_reg)
			OSF_ST_CMD: begin
				if (decide) begin
					cnt_next = 6'd0;
					if (refuse) begin
						state_next = OSF_ST_DONE;
					end else if (is_read) begin
						state_next = OSF_ST_OUT;
					end else begin
						state_next = OSF_ST_DONE;
					end
				end else if (cmd_done) begin
					cnt_next   = 6'd0;
					state_next = OSF_ST_ADDR;
				end
			end
			OSF_ST_ADDR: begin
				if (addr_done) begin
					cnt_next = 6'd0;
					if (refuse) begin
						state_next = OSF_ST_DONE;
					end else if (dummy != 6'd0) begin
						state_next = OSF_ST_DUMMY;
					end else if (is_read) begin
						state_next = OSF_ST_OUT;
					end else if (data_in) begin
						state_next = OSF_ST_IN;
					end else begin
						state_next = OSF_ST_DONE;
					end
				end
			end
			OSF_ST_DUMMY: begin
				if (cnt_reg == dummy - 6'd1) begin
					cnt_next   = 6'd0;
					state_next = OSF_ST_OUT;
				end
			end
			default: begin
			end
		endcase
	end

	wire out_active = (state_reg == OSF_ST_OUT) & ~refused_reg;
	wire ddr_out    = out_active & (data_w == OSF_W_DDR);

	assign col_next = addr_done ? addr_shift[12:0] :
		!out_active ? col_reg :
		(data_w == OSF_W_DDR) ? col_reg + 13'd2 :
		(data_w == OSF_W_OCTAL) ? col_reg + 13'd1 :
		(cnt_reg[2:0] == 3'd7) ? col_reg + 13'd1 : col_reg;

	assign addr_next = (state_reg == OSF_ST_ADDR) ? addr_shift : addr_reg;

	// Rising-edge logic, cleared whenever chip select is high
	always_ff @(posedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			state_reg    <= OSF_ST_CMD;
			cnt_reg      <= 6'd0;
			cmd_reg      <= 8'h0;
			addr_reg     <= 24'h0;
			col_reg      <= 13'h0;
			refused_reg  <= 1'b0;
			pos_byte_reg <= 8'h0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			cmd_reg      <= (state_reg == OSF_ST_CMD) ? cmd_full : cmd_reg;
			addr_reg     <= addr_next;
			col_reg      <= col_next;
			refused_reg  <= decide ? refuse : refused_reg;
			pos_byte_reg <= i_io;
		end
	end

	// Rising-edge launch of the second byte of each double rate pair
	always_ff @(posedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			pos_out_reg <= 8'h0;
			pos_ds_reg  <= 1'b0;
		end else if (ddr_out) begin
			pos_out_reg <= i_rd_data[15:8];
			pos_ds_reg  <= pos_ds_reg ^ ds_en;
		end
	end

	// Write data stream towards the page buffer
	always_ff @(posedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			wr_sh_reg  <= 8'h0;
			o_wr_data  <= 16'h0;
			o_wr_valid <= 2'b00;
		end else if (state_reg == OSF_ST_IN) begin
			wr_sh_reg  <= {wr_sh_reg[6:0], i_io[0]};
			o_wr_data  <= (data_w == OSF_W_DDR) ? {neg_byte_reg, pos_byte_reg} :
				(data_w == OSF_W_OCTAL) ? {8'h0, i_io} : {8'h0, wr_sh_reg[6:0], i_io[0]};
			o_wr_valid <= (data_w == OSF_W_DDR) ? 2'b11 :
				((data_w == OSF_W_OCTAL) | (cnt_reg[2:0] == 3'd7)) ? 2'b01 : 2'b00;
		end else begin
			o_wr_valid <= 2'b00;
		end
	end

	// Falling-edge capture and launch
	always_ff @(negedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			neg_byte_reg <= 8'h0;
			neg_out_reg  <= 8'h0;
			neg_ds_reg   <= 1'b0;
		end else begin
			neg_byte_reg <= i_io;
			if (out_active) begin
				neg_out_reg <= (data_w == OSF_W_SINGLE) ?
					{6'h0, i_rd_data[3'd7 - cnt_reg[2:0]], 1'b0} : i_rd_data[7:0];
				neg_ds_reg  <= neg_ds_reg ^ ds_en;
			end
		end
	end

	// Clock level picks the edge that launched the byte now on the pins
	assign o_io    = (ddr_out & i_sck) ? pos_out_reg : neg_out_reg;
	assign o_io_oe = !out_active ? 8'h00 :
		(data_w == OSF_W_SINGLE) ? 8'h02 : 8'hff;
	assign o_read_strobe_out = neg_ds_reg ^ pos_ds_reg;
	assign o_read_strobe_oe  = ds_en & is_read & ~refused_reg &
		(state_reg != OSF_ST_CMD) & (state_reg != OSF_ST_DONE);
	assign o_rd_addr = col_reg;

	// Announcement toggle survives hardware reset so that reset cannot fake an event
	always_ff @(posedge i_sck or negedge i_resetn) begin
		if (!i_resetn) begin
			evt_tog_reg   <= 1'b0;
			held_cmd_reg  <= 8'h0;
			held_addr_reg <= 24'h0;
			held_ref_reg  <= 1'b0;
		end else if (decide) begin
			evt_tog_reg   <= ~evt_tog_reg;
			held_cmd_reg  <= dec;
			held_addr_reg <= addr_dec;
			held_ref_reg  <= refuse;
		end
	end

	osf_sync #(.W(1), .RST_VAL(1'b0)) u_evt_sync (
		.i_clk   (i_sys_clk),
		.i_rst_n (i_resetn),
		.i_d     (evt_tog_reg),
		.o_q     (evt_s)
	);
	assign evt_seen = evt_s ^ evt_prev_reg;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			evt_prev_reg  <= 1'b0;
			o_cmd_valid   <= 1'b0;
			o_cmd         <= 8'h0;
			o_addr        <= 24'h0;
			o_cmd_refused <= 1'b0;
		end else begin
			evt_prev_reg <= evt_s;
			o_cmd_valid  <= evt_seen;
			if (evt_seen) begin
				o_cmd         <= held_cmd_reg;
				o_addr        <= held_addr_reg;
				o_cmd_refused <= held_ref_reg;
			end
		end
	end

	assign o_hw_reset_active = ~hw_rst_s;
	assign o_selected        = ~cs_n_s;
endmodule // osf_front_end
`default_nettype wire

// file: osf_front_end_assertions.sv
// Port-level checker for the octal serial flash bus front end
`timescale 1ns/1ps
`default_nettype none
module osf_front_end_chk (
	input wire logic       i_sys_clk,
	input wire logic       i_resetn,
	input wire logic       i_hw_reset_n,
	input wire logic       i_sck,
	input wire logic       i_cs_n,
	input wire logic [7:0] i_io,
	input wire logic [7:0] o_io_oe,
	input wire logic       o_read_strobe_out,
	input wire logic       o_read_strobe_oe,
	input wire logic [7:0] i_vol_cfg,
	input wire logic       i_wp_enable,
	input wire logic       o_cmd_valid,
	input wire logic [7:0] o_cmd,
	input wire logic       o_cmd_refused,
	input wire logic       o_hw_reset_active,
	input wire logic       o_selected
);
	wire ddr = (i_vol_cfg == 8'he7) || (i_vol_cfg == 8'hc7);
	wire wr_cmd = (o_cmd == 8'h10) || (o_cmd == 8'hd8) || (o_cmd == 8'h01) || (o_cmd == 8'h1f);
	wire oct_rd = (o_cmd == 8'h8b) || (o_cmd == 8'hcb);

	a_deselect_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		i_cs_n |-> o_io_oe == 8'h00) else $error("pins driven while deselected");
	a_hwreset_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_hw_reset_n |-> o_io_oe == 8'h00 && !o_read_strobe_oe) else $error("drive in reset");
	a_hwreset_flag: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!i_hw_reset_n [*6] |-> o_hw_reset_active) else $error("reset flag missing");
	a_oe_pattern: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_io_oe inside {8'h00, 8'h02, 8'hff}) else $error("bad output enable pattern");
	a_strobe_cfg: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_read_strobe_oe |-> i_vol_cfg[5]) else $error("strobe driven while disabled");
	a_strobe_start: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(o_read_strobe_oe) |-> !o_read_strobe_out) else $error("strobe not low at start");
	a_refused_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_cmd_valid && o_cmd_refused |-> o_io_oe == 8'h00 && !o_read_strobe_oe)
		else $error("refused command drives pins");
	a_octal_lock: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_cmd_valid && i_wp_enable && oct_rd |-> o_cmd_refused) else $error("octal read taken");
	a_wp_writes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_cmd_valid && i_wp_enable && !i_io[2] && !ddr && wr_cmd |-> o_cmd_refused)
		else $error("write accepted under protect");
	a_valid_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_cmd_valid |=> !o_cmd_valid) else $error("command pulse too long");
	a_select_sync: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!i_cs_n && i_hw_reset_n) [*6] |-> o_selected) else $error("select not seen");
	a_strobe_toggle: assert property (@(posedge i_sck) disable iff (i_cs_n || !i_hw_reset_n)
		o_read_strobe_oe && !ddr && o_io_oe != 8'h00 && $past(o_io_oe) != 8'h00
		|-> o_read_strobe_out != $past(o_read_strobe_out)) else $error("strobe did not toggle");

	c_taken: cover property (@(posedge i_sys_clk) o_cmd_valid && !o_cmd_refused);
	c_refused: cover property (@(posedge i_sys_clk) o_cmd_valid && o_cmd_refused);
	c_strobe: cover property (@(posedge i_sys_clk) $rose(o_read_strobe_oe));
	c_hwreset: cover property (@(posedge i_sys_clk) o_hw_reset_active);
endmodule // osf_front_end_chk

bind osf_front_end osf_front_end_chk u_chk (.i_sys_clk, .i_resetn, .i_hw_reset_n, .i_sck,
	.i_cs_n, .i_io, .o_io_oe, .o_read_strobe_out, .o_read_strobe_oe, .i_vol_cfg, .i_wp_enable,
	.o_cmd_valid, .o_cmd, .o_cmd_refused, .o_hw_reset_active, .o_selected);
`default_nettype wire

// file: osf_host_model.sv
// Host controller model driving serial clock, chip select and data pins
`timescale 1ns/1ps
`default_nettype none
module osf_host_model (
	output logic            o_sck,
	output logic            o_cs_n,
	output logic      [7:0] o_drv,
	output logic      [7:0] o_drv_en,
	input  wire logic       i_wp,
	input  wire logic [7:0] i_pin
);
	logic idle_hi;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_drv = 8'h00;
		o_drv_en = 8'h04;
		idle_hi = 1'b0;
	end
	// Clock rests at the idle level of the chosen mode across both select edges
	task automatic start(input logic m3);
		idle_hi = m3;
		o_sck = m3;
		#40;
		o_cs_n = 1'b0;
		#20;
	endtask
	// Drive after the falling edge, sample just before the rising edge
	task automatic xfer(input logic [7:0] d, input logic [7:0] en, output logic [7:0] q);
		o_sck = 1'b0;
		o_drv = d;
		o_drv_en = en;
		#16;
		q = i_pin;
		o_sck = 1'b1;
		#16;
	endtask
	task automatic bit_cyc(input logic b, output logic [7:0] q);
		xfer({5'h00, i_wp, 1'b0, b}, 8'h05, q);
	endtask
	task automatic rd_cyc(input logic oct, output logic [7:0] q);
		xfer({5'h00, i_wp, 2'h0}, oct ? 8'h00 : 8'h04, q);
	endtask
	// Byte-wide transfer on both edges: drive before each edge, sample just before it
	task automatic ddr_cyc(input logic [7:0] dr, input logic [7:0] df, input logic [7:0] en,
		output logic [7:0] qr, output logic [7:0] qf);
		o_drv = dr;
		o_drv_en = en;
		#8;
		qr = i_pin;
		o_sck = 1'b1;
		#8;
		o_drv = df;
		#8;
		qf = i_pin;
		o_sck = 1'b0;
		#8;
	endtask
	task automatic stop();
		if (!idle_hi) o_sck = 1'b0;
		#200;
		o_cs_n = 1'b1;
		o_drv_en = 8'h04;
		#200;
	endtask
endmodule // osf_host_model
`default_nettype wire

// file: osf_pkg.sv
// Types for the octal serial flash bus front end
package osf_pkg;
	typedef enum logic [2:0] {
		OSF_ST_CMD   = 3'b000,
		OSF_ST_ADDR  = 3'b001,
		OSF_ST_DUMMY = 3'b010,
		OSF_ST_OUT   = 3'b011,
		OSF_ST_IN    = 3'b100,
		OSF_ST_DONE  = 3'b101
	} osf_state_t;

	typedef enum logic [1:0] {
		OSF_W_SINGLE = 2'b00,
		OSF_W_OCTAL  = 2'b01,
		OSF_W_DDR    = 2'b10
	} osf_width_t;
endpackage

// file: osf_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module osf_sync #(
	parameter int          W      = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_next;

	// A bit changes only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			assign q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : o_q[g];
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			o_q    <= RST_VAL;
		end else begin
			s1_reg <= i_d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			o_q    <= q_next;
		end
	end
endmodule // osf_sync
`default_nettype wire

// file: test_octal_serial_flash_bus_front_end.sv
// Self-checking bench for the octal serial flash bus front end
`timescale 1ns/1ps
`default_nettype none
module test_octal_serial_flash_bus_front_end;
	logic        i_sys_clk;
	logic        i_resetn;
	logic        hw_n;
	logic [7:0]  cfg;
	logic        wp_en;
	logic        wp;
	logic        nz;
	logic [7:0]  mem [8192];
	logic [32:0] exp_q [$];
	logic [32:0] act_q [$];
	int          mismatches;
	int          checked;
	int          cyc;
	wire         sck;
	wire         cs_n;
	wire         ds;
	wire         ds_oe;
	wire         cv;
	wire         rf;
	wire         hra;
	wire  [7:0]  drv;
	wire  [7:0]  drv_en;
	wire  [7:0]  pin;
	wire  [7:0]  io_o;
	wire  [7:0]  io_oe;
	wire  [7:0]  cmd;
	wire  [12:0] rd_addr;
	wire  [15:0] rd_data;
	wire  [23:0] addr;
	wire  [15:0] wd;
	wire  [1:0]  wv;
	logic [17:0] wr_q [$];

	// Released lines show a changing pattern instead of a held value
	assign pin = (io_oe & io_o) | (~io_oe & drv_en & drv) | (~io_oe & ~drv_en & {4{nz, ~nz}});
	assign rd_data = {mem[rd_addr + 13'h1], mem[rd_addr]};

	osf_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_drv(drv), .o_drv_en(drv_en),
		.i_wp(wp), .i_pin(pin));
	osf_front_end uut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_hw_reset_n(hw_n),
		.i_sck(sck), .i_cs_n(cs_n), .i_io(pin), .o_io(io_o), .o_io_oe(io_oe),
		.o_read_strobe_out(ds), .o_read_strobe_oe(ds_oe), .i_vol_cfg(cfg),
		.i_wp_enable(wp_en), .i_block_protect_level(4'h0), .i_status_protect_bits(2'h0),
		.o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_data(wd), .o_wr_valid(wv),
		.o_cmd_valid(cv), .o_cmd(cmd), .o_addr(addr), .o_cmd_refused(rf),
		.o_hw_reset_active(hra), .o_selected());

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		nz <= ~nz;
		if (cv === 1'b1) act_q.push_back({cmd, rf, addr});
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			end_sim();
		end
	end
	// Write data pulses stand for one link cycle; the falling edge sees them settled
	always @(negedge sck) begin
		if (wv !== 2'b00) wr_q.push_back({wv, wd});
	end

	task automatic end_sim();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic res();
		repeat (12) @(posedge i_sys_clk);
		chk(33'(act_q.size()), 33'(exp_q.size()));
		while (exp_q.size() > 0 && act_q.size() > 0) chk(act_q.pop_front(), exp_q.pop_front());
		exp_q.delete();
		act_q.delete();
		wr_q.delete();
		#1;
	endtask
	task automatic hreset();
		@(posedge i_sys_clk) #1 hw_n = 1'b0;
		#1 chk(33'({ds_oe, io_oe}), 33'h0);
		repeat (8) @(posedge i_sys_clk);
		chk(33'(hra), 33'h1);
		repeat (42) @(posedge i_sys_clk);
		#1 hw_n = 1'b1;
		repeat (8) @(posedge i_sys_clk);
		chk(33'(hra), 33'h0);
	endtask
	task automatic frame(input logic [7:0] c, input logic m3, input int na, input int nd,
		input logic oct, input logic rx, input logic hr);
		logic [7:0]  q;
		logic [7:0]  g;
		logic [7:0]  e;
		logic [23:0] a;
		int          i;
		int          k;
		a = 24'($urandom) & (na == 16 ? 24'h000fff : 24'hffffff);
		host.start(m3);
		for (i = 7; i >= 0; i--) host.bit_cyc(c[i], q);
		for (i = na - 1; i >= 0; i--) host.bit_cyc(a[i], q);
		if (nd > 0 && c != 8'h02) repeat (8) host.bit_cyc(1'b0, q);
		exp_q.push_back({c, rx, a});
		for (k = 0; k < nd * 8 && c == 8'h02; k++) host.bit_cyc(mem[k / 8][7 - k % 8], q);
		for (k = 0; k < nd * (oct ? 1 : 8) && c != 8'h02; k++) begin
			if (hr && k == 3) begin
				hreset();
				break;
			end
			host.rd_cyc(oct, q);
			e = oct ? mem[a[12:0] + k] : {7'h0, mem[a[12:0] + k / 8][7 - k % 8]};
			g = oct ? q : {7'h0, q[1]};
			if (rx) chk(33'(io_oe), 33'h0);
			else begin
				chk(33'(g), 33'(e));
				chk(33'(io_oe), oct ? 33'hff : 33'h02);
			end
			chk(33'(ds_oe), 33'(cfg[5] & ~rx));
		end
		host.stop();
		chk(33'(io_oe), 33'h0);
		if (c == 8'h02) chk(33'(wr_q.size()), 33'(nd));
		for (i = 0; i < nd && c == 8'h02 && wr_q.size() > 0; i++)
			chk(33'(wr_q.pop_front()), {15'h0, 2'b01, 8'h00, mem[i]});
		res();
	endtask

	initial begin : main
		logic [7:0] q;
		logic [7:0] q2;
		logic [15:0] ad;
		int         j;
		int         m;
		i_resetn = 1'b0;
		hw_n = 1'b1;
		cfg = 8'hff;
		wp_en = 1'b0;
		wp = 1'b1;
		nz = 1'b0;
		mismatches = 0;
		checked = 0;
		cyc = 0;
		void'($urandom(32'h35d0));
		for (j = 0; j < 8192; j++) mem[j] = 8'($urandom);
		repeat (6) @(posedge i_sys_clk);
		#1 i_resetn = 1'b1;
		repeat (6) @(posedge i_sys_clk);
		// Aborted frame also gives the configuration crossing its first link edges
		host.start(1'b0);
		repeat (4) host.bit_cyc(1'b1, q);
		host.stop();
		res();
		frame(8'h0b, 1'b0, 16, 2, 1'b0, 1'b0, 1'b0);
		cfg = 8'hdf;
		frame(8'h0b, 1'b1, 16, 2, 1'b0, 1'b0, 1'b0);
		frame(8'h8b, 1'b0, 16, 2, 1'b1, 1'b0, 1'b0);
		wp_en = 1'b1;
		frame(8'h8b, 1'b0, 16, 1, 1'b1, 1'b1, 1'b0);
		for (m = 0; m < 4; m++) begin
			{wp_en, wp} = 2'(m);
			frame(8'h10, 1'b0, 24, 0, 1'b0, m == 2, 1'b0);
		end
		cfg = 8'hff;
		frame(8'h0b, 1'b0, 16, 2, 1'b0, 1'b0, 1'b1);
		frame(8'h0b, 1'b0, 16, 1, 1'b0, 1'b0, 1'b0);
		frame(8'h02, 1'b0, 16, 2, 1'b0, 1'b0, 1'b0);
		// Double rate: a short aborted frame lets the new configuration reach the link side
		wp_en = 1'b0;
		cfg = 8'he7;
		host.start(1'b0);
		repeat (4) host.bit_cyc(1'b1, q);
		host.stop();
		res();
		ad = 16'($urandom) & 16'h0fff;
		host.start(1'b0);
		host.ddr_cyc(8'h0b, 8'h00, 8'hff, q, q2);
		host.ddr_cyc(ad[15:8], ad[7:0], 8'hff, q, q2);
		repeat (9) host.ddr_cyc(8'h00, 8'h00, 8'h00, q, q2);
		exp_q.push_back({8'h0b, 1'b0, 8'h00, ad});
		for (j = 0; j < 4; j += 2) begin
			host.ddr_cyc(8'h00, 8'h00, 8'h00, q, q2);
			chk(33'(q), 33'(mem[ad[12:0] + j]));
			chk(33'(q2), 33'(mem[ad[12:0] + j + 1]));
			chk(33'({ds_oe, io_oe}), 33'h1ff);
		end
		host.stop();
		res();
		end_sim();
	end
endmodule // test_octal_serial_flash_bus_front_end
`default_nettype wire
